// ==== core/nvm_defs.svh ====
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH
// Register word indices as printed, byte address is four times the index
`define NVM_IDX_CONTROL 8'h1C
`define NVM_IDX_DATA 8'h1D
`define NVM_IDX_ADDRESS 8'h1E
`define NVM_ADDR_CONTROL 12'h070
`define NVM_ADDR_DATA 12'h074
`define NVM_ADDR_ADDRESS 12'h078
// Control register fields
`define NVM_BIT_BUSY 3
`define NVM_BIT_UNLOCK 2
`define NVM_BIT_LOAD 1
`define NVM_BIT_READ 0
// Address register fields
`define NVM_PAGE_HI 6
`define NVM_PAGE_LO 3
`define NVM_BYTE_HI 2
`define NVM_BYTE_LO 0
`define NVM_REG_RESET 8'h00
`define NVM_PAGE_BYTES 8
`define NVM_MEM_BYTES 128
// Programming time in microseconds and clock rate in kHz
`define NVM_PROG_US 4000
`define NVM_CLK_KHZ 25000
`define NVM_PROG_CYCLES ((`NVM_PROG_US * `NVM_CLK_KHZ) / 1000)
// Cycles spent in the start state between load falling and the timed window
`define NVM_START_DELAY 2
`endif

// ==== core/nvm_pkg.sv ====
package nvm_pkg;
	typedef enum logic [1:0] {NVM_IDLE, NVM_START, NVM_PROG} nvm_state_t;
endpackage

// ==== core/nvm_page_access.sv ====
`timescale 1ns/1ps
`include "nvm_defs.svh"
module nvm_page_access
	import nvm_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `NVM_PROG_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_program_in_progress
);
	logic [7:0] mem [0:`NVM_MEM_BYTES-1];
	logic [7:0] pbuf [0:`NVM_PAGE_BYTES-1];
	logic [`NVM_PAGE_BYTES-1:0] pvalid_ff;
	logic unlock_ff, load_ff, read_ff;
	logic [7:0] data_ff;
	logic [3:0] page_ff;
	logic [2:0] bsel_ff;
	logic [31:0] prdata_ff;
	logic [31:0] cnt_ff;
	nvm_state_t state_ff;
	logic [3:0] lock_page_ff;

	// Bus decode; every access completes with no wait state
	wire acc = i_psel & i_penable;
	wire wr = acc & i_pwrite;
	wire hit_ctl = (i_paddr == `NVM_ADDR_CONTROL);
	wire hit_dat = (i_paddr == `NVM_ADDR_DATA);
	wire hit_adr = (i_paddr == `NVM_ADDR_ADDRESS);
	wire mapped = hit_ctl | hit_dat | hit_adr;
	wire wr_ctl = wr & hit_ctl;
	wire wr_dat = wr & hit_dat;
	wire wr_adr = wr & hit_adr;
	wire busy = (state_ff != NVM_IDLE);
	wire nxt_load = unlock_ff ? i_pwdata[`NVM_BIT_LOAD] : load_ff;
	wire load_fall = wr_ctl & load_ff & ~nxt_load & unlock_ff;
	wire [6:0] rd_addr = {page_ff, bsel_ff};
	wire [7:0] ctl_val = {4'h0, busy, unlock_ff, load_ff, read_ff};
	wire [7:0] adr_val = {1'b0, page_ff, bsel_ff};
	wire [7:0] rd_mux = hit_ctl ? ctl_val : hit_dat ? data_ff :
		hit_adr ? adr_val : 8'h00;
	assign o_pready = 1'b1;
	assign o_pslverr = acc & ~mapped;
	assign o_prdata = prdata_ff;
	assign o_program_in_progress = busy;

	// Read data registered on the setup cycle so it is ready at access
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) prdata_ff <= 32'h0000_0000;
		else if (i_psel & ~i_penable & ~i_pwrite) prdata_ff <= {24'h0, rd_mux};
	end

	// Control bits; read clears itself one cycle after being set
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			unlock_ff <= 1'b0;
			load_ff <= 1'b0;
			read_ff <= 1'b0;
		end else if (wr_ctl) begin
			unlock_ff <= i_pwdata[`NVM_BIT_UNLOCK];
			load_ff <= nxt_load;
			read_ff <= i_pwdata[`NVM_BIT_READ];
		end else begin
			read_ff <= 1'b0;
		end
	end

	// Address register; page frozen while load set
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			page_ff <= 4'h0;
			bsel_ff <= 3'h0;
		end else if (wr_adr) begin
			if (!load_ff)
				page_ff <= i_pwdata[`NVM_PAGE_HI:`NVM_PAGE_LO];
			bsel_ff <= i_pwdata[`NVM_BYTE_HI:`NVM_BYTE_LO];
		end
	end

	// Data register: software writes win, read fetch loads memory byte
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) data_ff <= `NVM_REG_RESET;
		else if (wr_dat) data_ff <= i_pwdata[7:0];
		else if (read_ff && !busy) data_ff <= mem[rd_addr];
	end

	// Page buffer valid flags; cleared when programming ends
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) pvalid_ff <= '0;
		else if (state_ff == NVM_PROG && cnt_ff == 32'd0)
			pvalid_ff <= '0;
		else if (wr_dat && load_ff) pvalid_ff[bsel_ff] <= 1'b1;
	end

	// Buffer bytes need no reset; valid flags qualify them
	always_ff @(posedge i_sys_clk) begin
		if (wr_dat && load_ff) pbuf[bsel_ff] <= i_pwdata[7:0];
	end

	// Programming sequencer: short start delay then timed busy window
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= NVM_IDLE;
			cnt_ff <= 32'd0;
			lock_page_ff <= 4'h0;
		end else begin
			unique case (state_ff)
				NVM_IDLE: if (load_fall) begin
					state_ff <= NVM_START;
					lock_page_ff <= page_ff;
					cnt_ff <= `NVM_START_DELAY - 1;
				end
				NVM_START: if (cnt_ff == 32'd0) begin
					state_ff <= NVM_PROG;
					cnt_ff <= PROG_CYCLES - 1;
				end else cnt_ff <= cnt_ff - 32'd1;
				NVM_PROG: if (cnt_ff == 32'd0) state_ff <= NVM_IDLE;
					else cnt_ff <= cnt_ff - 32'd1;
				default: state_ff <= NVM_IDLE;
			endcase
		end
	end

	// Array cells written at the end of the programming window
	generate
		for (genvar b = 0; b < `NVM_PAGE_BYTES; b++) begin : g_prog
			always_ff @(posedge i_sys_clk) begin
				if (state_ff == NVM_PROG && cnt_ff == 32'd0 && pvalid_ff[b])
					mem[{lock_page_ff, 3'(b)}] <= pbuf[b];
			end
		end
	endgenerate

	// Busy window length equals the programming count plus the start delay
	logic [31:0] busy_len_ff;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) busy_len_ff <= 32'd0;
		else if (busy) busy_len_ff <= busy_len_ff + 32'd1;
		else busy_len_ff <= 32'd0;
	end

	// Programming start: a qualified load fall, then the start delay states
	sequence s_fall;
		load_fall && state_ff == NVM_IDLE;
	endsequence
	sequence s_busy_up;
		##[1:3] o_program_in_progress;
	endsequence
	sequence s_start_gap;
		state_ff == NVM_START [*2];
	endsequence

	// Busy follows a load fall within a few cycles
	busy_rise_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		s_fall |-> s_busy_up)
		else $error("busy did not rise after load fall");

	// The count sampled at the falling edge already covers the last cycle
	busy_len_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		$fell(busy) |-> busy_len_ff == PROG_CYCLES + `NVM_START_DELAY)
		else $error("programming window length wrong");

	// Locked control writes leave the load bit alone
	lock_gate_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_ctl && !unlock_ff |=> load_ff == $past(load_ff))
		else $error("load changed while locked");

	// Page bits frozen while a page is being loaded
	page_hold_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		load_ff |=> page_ff == $past(page_ff))
		else $error("page changed under load");

	// Read bit drops by itself one cycle after being set
	read_clear_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		read_ff && !wr_ctl |=> !read_ff)
		else $error("read bit stuck");

	// Fetch lands in the data register on the next edge
	read_fetch_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		read_ff && !busy && !wr_dat |=> data_ff == mem[$past(rd_addr)])
		else $error("read data not fetched");

	// Buffer is empty once programming has finished
	buf_clear_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		$fell(busy) |-> pvalid_ff == '0)
		else $error("page buffer not cleared");

	// Reserved bits read zero and busy bit mirrors the sequencer
	ctl_view_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		ctl_val[7:4] == 4'h0 && ctl_val[3] == o_program_in_progress)
		else $error("control view wrong");

	// Data register only moves on a software write or a fetch
	data_hold_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!wr_dat && !read_ff |=> $stable(data_ff))
		else $error("data changed");

	// A data write under load marks its byte as loaded
	load_capt_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_dat && load_ff && !busy |=> pvalid_ff[$past(bsel_ff)])
		else $error("byte not buffered");

	// Exact start sequence: two start states, then the timed window
	prog_start_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		s_fall |=> s_start_gap ##1 (state_ff == NVM_PROG))
		else $error("programming start sequence wrong");

	// Target page must not move while the array is written
	page_freeze_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		state_ff != NVM_IDLE |=> $stable(lock_page_ff))
		else $error("locked page moved during programming");

	// Unlocked page bits take the written value
	page_write_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_adr && !load_ff |=>
			page_ff == $past(i_pwdata[`NVM_PAGE_HI:`NVM_PAGE_LO]))
		else $error("page bits not written");

	// Byte select always follows the address write
	byte_write_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_adr |=> bsel_ff == $past(i_pwdata[`NVM_BYTE_HI:`NVM_BYTE_LO]))
		else $error("byte select not written");

	// Unlock bit is plain read/write
	unlock_set_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_ctl |=> unlock_ff == $past(i_pwdata[`NVM_BIT_UNLOCK]))
		else $error("unlock bit not written");

	// Nothing starts from idle while the array is locked
	locked_idle_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!unlock_ff && state_ff == NVM_IDLE |=> state_ff == NVM_IDLE)
		else $error("programming started while locked");

	// Buffered byte holds the written data
	buf_byte_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_dat && load_ff |=> pbuf[$past(bsel_ff)] == $past(i_pwdata[7:0]))
		else $error("buffered byte wrong");

	// A read request during programming leaves the data register alone
	read_busy_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		read_ff && busy && !wr_dat |=> $stable(data_ff))
		else $error("data changed by read while busy");

	// Software write to the data register lands as written
	data_wr_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_dat |=> data_ff == $past(i_pwdata[7:0]))
		else $error("data write lost");

	// Error response only for unmapped addresses
	err_map_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		acc |-> o_pslverr == !mapped)
		else $error("slave error response wrong");

	// Every access completes without wait states
	ready_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		acc |-> o_pready)
		else $error("access not ready");

	// Loaded byte 0 of the page reaches the array at the end of the window
	prog_commit_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		state_ff == NVM_PROG && cnt_ff == 32'd0 && pvalid_ff[0] |=>
			mem[{$past(lock_page_ff), 3'h0}] == $past(pbuf[0]))
		else $error("loaded byte not programmed");

	// The timed window does not end early
	cnt_run_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		state_ff == NVM_PROG && cnt_ff != 32'd0 |=> state_ff == NVM_PROG)
		else $error("programming window cut short");

	// Outside a load session no stale byte waits in the buffer
	idle_buf_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		state_ff == NVM_IDLE && !load_ff |-> pvalid_ff == '0)
		else $error("stale byte left in buffer");
endmodule

// ==== sim/nvm_sw_model.sv ====
`timescale 1ns/1ps
// Software on the register bus; zeros go to upper bits
module nvm_sw_model (
	input wire logic i_clk,
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [11:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic o_rd_vld,
	output logic [7:0] o_rd_data,
	output logic o_hang
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h00000000;
		o_rd_vld = 1'b0;
		o_rd_data = 8'h00;
		o_hang = 1'b0;
	end
	// Held until pready; a stuck slave raises the hang flag
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= wr;
		o_paddr <= a;
		o_pwdata <= {24'h000000, d};
		@(posedge i_clk);
		o_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 50);
		o_hang <= (n >= 50);
		o_rd_vld <= !wr;
		o_rd_data <= i_prdata[7:0];
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		@(posedge i_clk);
		o_rd_vld <= 1'b0;
	endtask
endmodule

// ==== sim/data_eeprom_page_access_tb.sv ====
`timescale 1ns/1ps
module data_eeprom_page_access_tb;
	localparam int unsigned PROG = 20;
	logic clk, rstn, psel, pen, pwr, pready, perr, busy, rd_vld, hang;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] rd_data, d0, d1, q[$];
	logic [3:0] pg;
	int bad_count, checks, bcnt, n;
	nvm_page_access #(.PROG_CYCLES(PROG)) dut_u (.i_sys_clk(clk),
		.i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(perr), .o_program_in_progress(busy));
	nvm_sw_model sw_u (.i_clk(clk), .i_prdata(prdata), .i_pready(pready),
		.o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr),
		.o_pwdata(pwdata), .o_rd_vld(rd_vld), .o_rd_data(rd_data),
		.o_hang(hang));
	initial clk = 1'b0;
	always #20 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Note the expected byte, then run the read
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		q.push_back(e);
		sw_u.xfer(1'b0, a, 8'h00);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		sw_u.xfer(1'b1, a, d);
	endtask
	// Bounded wait; a flag that never moves ends the run
	task automatic wait_busy(input logic v);
		int k;
		k = 0;
		while (busy !== v && k < 200) begin
			@(posedge clk);
			k++;
		end
		check(32'(busy), 32'(v));
		if (k >= 200) final_report();
	endtask
	// Oldest note against each read result; busy cycles counted
	always @(posedge clk) begin
		if (busy === 1'b1) bcnt++;
		if (hang === 1'b1) begin
			bad_count++;
			final_report();
		end
		if (rd_vld === 1'b1) check(32'(rd_data), 32'(q.pop_front()));
		if (psel === 1'b1 && pen === 1'b1)
			check(32'(perr), 32'(paddr == 12'h07C));
	end
	initial begin
		rstn = 1'b0;
		bad_count = 0;
		checks = 0;
		bcnt = 0;
		n = $urandom(18856);
		pg = 4'($urandom);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(12'h070, 8'h00);
		rd(12'h074, 8'h00);
		rd(12'h078, 8'h00);
		rd(12'h07C, 8'h00);
		wr(12'h070, 8'h02);
		rd(12'h070, 8'h00);
		wr(12'h070, 8'h04);
		wr(12'h078, {1'b0, pg, 3'h0});
		wr(12'h070, 8'h06);
		wr(12'h074, d0);
		wr(12'h078, {1'b0, ~pg, 3'h1});
		rd(12'h078, {1'b0, pg, 3'h1});
		wr(12'h074, d1);
		wr(12'h070, 8'h04);
		wait_busy(1'b1);
		rd(12'h070, 8'h0C);
		wait_busy(1'b0);
		wr(12'h070, 8'h00);
		wr(12'h078, {1'b0, pg, 3'h0});
		wr(12'h070, 8'h01);
		rd(12'h070, 8'h00);
		rd(12'h074, d0);
		wr(12'h078, {1'b0, pg, 3'h1});
		wr(12'h070, 8'h01);
		rd(12'h074, d1);
		rd(12'h074, d1);
		check(32'(bcnt), 32'(PROG + 2));
		final_report();
	end
endmodule
